// ---- fbp_core.sv ----
// Purpose: fault protection and sequencing of a current-mode flyback controller
// Assumes: comparator and supply monitor levels arrive asynchronously
// Notes:   gate_drive_o is the only path that turns the external switch on
//
// Function
// - four consecutive abnormal over-currents cause fault-off
// - clean pulse clears the abnormal over-current counter
// - ignore abnormal comparator 120 ns after turn-on
// - abnormal trip level sits at 1.2 V
// - abnormal fault latches or auto-recovers per option
// - supply over-voltage over 20 us stops pulses
// - latched over-voltage cleared by supply reset, brown-out
// - open sense pin keeps controller disabled
// - pulse ends by 80% of period
// - duty-limited pulses run overload timer to fault
// - soft-start reference ramps 0 to limit 8 ms
// - over-temperature disables, restarts after hysteresis cool-down
// - thermal fault also cleared by reset, brown-out
// - restart only at next start crossing, faults gone
// - over-current and overload auto-recovery waits one second before restarting
// - latched state keeps drive off, supply hiccups

`timescale 1ns/100ps

module fbp_core #(
   parameter int PERIOD_CYC = fbp_pkg::PERIOD_CYC,
   parameter int OV_CYC     = fbp_pkg::OV_QUAL_CYC,
   parameter int SS_CYC     = fbp_pkg::SS_DURATION_CYC,
   parameter int REC_CYC    = fbp_pkg::RECOVERY_CYC,
   parameter int OVLD_CYC   = fbp_pkg::OVLD_TIMER_CYC,
   parameter bit OCP_LATCH  = 1'b1,
   parameter bit OVP_LATCH  = 1'b1,
   parameter bit PIN_LATCH  = 1'b1
) (
   // clock and reset
   input  wire logic                      sys_clk_i,
   input  wire logic                      sys_rst_i,
   // analog comparators and supply monitors
   input  wire fbp_pkg::fbp_in_s          pins_i,
   // gate drive and supply control
   output logic                           gate_drive_o,
   output logic                           hv_start_o,
   output logic [fbp_pkg::SS_W-1:0]       soft_start_ref_o,
   // status
   output fbp_pkg::fbp_flt_s              fault_o,
   output fbp_pkg::fbp_st_e               state_o
);

   // ----------------------------------------------------------------
   // derived counts
   // ----------------------------------------------------------------
   localparam int BLANK   = fbp_pkg::SHORT_BLANK_CYC;
   localparam int MAX_ON  = PERIOD_CYC * fbp_pkg::MAX_DUTY_PCT / 100;
   localparam int SS_STEP = (SS_CYC >> fbp_pkg::SS_W) > 0 ? (SS_CYC >> fbp_pkg::SS_W) : 1;

   if (PERIOD_CYC < 2 * BLANK || PERIOD_CYC >= 2 ** fbp_pkg::PER_W || MAX_ON <= BLANK ||
       OV_CYC < 1 || REC_CYC < 1 || OVLD_CYC < 1 ||
       SS_STEP >= 2 ** fbp_pkg::TMR_W || OV_CYC >= 2 ** fbp_pkg::TMR_W ||
       REC_CYC >= 2 ** fbp_pkg::TMR_W || OVLD_CYC >= 2 ** fbp_pkg::TMR_W) begin : g_bad_param
      $error("fbp_core: parameter out of range");
   end

   // ----------------------------------------------------------------
   // input synchronisation
   // ----------------------------------------------------------------
   logic [$bits(fbp_pkg::fbp_in_s)-1:0] pins_sync;
   fbp_pkg::fbp_in_s                    in;

   fbp_sync #(
      .W ($bits(fbp_pkg::fbp_in_s))
   ) u_sync (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .d_i       (pins_i),
      .q_o       (pins_sync)
   );

   assign in = fbp_pkg::fbp_in_s'(pins_sync);

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   fbp_pkg::fbp_state_s st_ff;
   fbp_pkg::fbp_state_s nxt;
   logic                on_rise;
   logic                bo_rise;
   logic                bo_fall;
   logic                clr_all;
   logic                pulse_end;
   logic                aoc_trip;
   logic                duty_end;
   logic                set_aoc;
   logic                set_ovld;
   logic                set_ovp;
   logic                rec_done;
   logic                any_flt;

   assign on_rise = in.vcc_on & ~st_ff.vcc_on_prev;
   assign bo_rise = in.bo_ok & ~st_ff.bo_prev;
   assign bo_fall = ~in.bo_ok & st_ff.bo_prev;
   assign clr_all = in.vcc_reset | bo_rise;

   always_comb begin
      nxt             = st_ff;
      nxt.vcc_on_prev = in.vcc_on;
      nxt.bo_prev     = in.bo_ok;
      pulse_end       = 1'b0;
      aoc_trip        = 1'b0;
      duty_end        = 1'b0;
      set_aoc         = 1'b0;
      set_ovld        = 1'b0;
      set_ovp         = 1'b0;
      rec_done        = 1'b0;

      // supply hiccup between minimum and start levels outside run
      if (st_ff.st == fbp_pkg::FBP_RUN) begin
         nxt.hv = 1'b0;
      end else if (!in.vcc_above_min) begin
         nxt.hv = 1'b1;
      end else if (in.vcc_on) begin
         nxt.hv = 1'b0;
      end

      if (st_ff.st == fbp_pkg::FBP_RUN) begin
         nxt.per = (32'(st_ff.per) == PERIOD_CYC - 1) ? '0 : st_ff.per + 16'h1;
         if (st_ff.gate) begin
            // the analog side compares against the 1.2 V trip level
            aoc_trip  = in.aoc_cmp && (32'(st_ff.per) > BLANK);
            duty_end  = 32'(st_ff.per) == MAX_ON;
            pulse_end = aoc_trip | in.ilim_cmp | in.ss_cmp | duty_end;
         end else if (st_ff.per == '0) begin
            nxt.gate = 1'b1;
         end
         if (pulse_end) begin
            nxt.gate = 1'b0;
            if (!aoc_trip) begin
               nxt.aoc_cnt = '0;
            end else if (32'(st_ff.aoc_cnt) == fbp_pkg::AOC_LIMIT - 1) begin
               nxt.aoc_cnt = '0;
               set_aoc     = 1'b1;
            end else begin
               nxt.aoc_cnt = st_ff.aoc_cnt + 3'h1;
            end
            if (in.ilim_cmp | in.ss_cmp) begin
               nxt.ovld_on = 1'b0;
            end else if (duty_end) begin
               nxt.ovld_on = 1'b1;
            end
         end
         if (st_ff.ovld_on) begin
            nxt.ovld_tmr = st_ff.ovld_tmr + fbp_pkg::TMR_ONE;
            set_ovld     = 32'(st_ff.ovld_tmr) == OVLD_CYC - 1;
         end else begin
            nxt.ovld_tmr = '0;
         end
         // setpoint capped by the ramp; it restarts at every start-up
         if (st_ff.ss_ref != '1) begin
            if (32'(st_ff.ss_div) == SS_STEP - 1) begin
               nxt.ss_div = '0;
               nxt.ss_ref = st_ff.ss_ref + 8'h1;
            end else begin
               nxt.ss_div = st_ff.ss_div + fbp_pkg::TMR_ONE;
            end
         end
      end else begin
         nxt.per      = '0;
         nxt.gate     = 1'b0;
         nxt.aoc_cnt  = '0;
         nxt.ovld_on  = 1'b0;
         nxt.ovld_tmr = '0;
         nxt.ss_ref   = '0;
         nxt.ss_div   = '0;
      end

      // over-voltage must stand longer than the qualification time
      if (in.vcc_ov) begin
         if (32'(st_ff.ov_tmr) != OV_CYC) begin
            nxt.ov_tmr = st_ff.ov_tmr + fbp_pkg::TMR_ONE;
         end
         set_ovp = 32'(st_ff.ov_tmr) == OV_CYC;
      end else begin
         nxt.ov_tmr = '0;
      end

      // auto-recovery wait; a line recovery cuts it short
      if (st_ff.rec_run) begin
         rec_done    = 32'(st_ff.rec_tmr) == REC_CYC - 1;
         nxt.rec_tmr = st_ff.rec_tmr + fbp_pkg::TMR_ONE;
      end
      if (!OCP_LATCH && (set_aoc || set_ovld)) begin
         nxt.rec_run = 1'b1;
         nxt.rec_tmr = '0;
      end else if (rec_done || bo_rise) begin
         nxt.rec_run = 1'b0;
      end

      // set always wins over clear
      nxt.flt.aoc  = set_aoc  | (st_ff.flt.aoc  &
                     ~(clr_all | (!OCP_LATCH & rec_done)));
      nxt.flt.ovld = set_ovld | (st_ff.flt.ovld &
                     ~(clr_all | (!OCP_LATCH & rec_done)));
      nxt.flt.supply_overvoltage_guard  = set_ovp  | (st_ff.flt.supply_overvoltage_guard  &
                     ~(clr_all | (!OVP_LATCH & !in.vcc_ov)));
      nxt.flt.otp  = in.therm_hot | (st_ff.flt.otp &
                     ~(in.therm_cool | in.vcc_reset | bo_fall));
      nxt.flt.pin  = in.fault_pin | (st_ff.flt.pin &
                     ~(clr_all | (!PIN_LATCH & !in.fault_pin)));

      any_flt = (|nxt.flt) | in.cs_open;

      case (st_ff.st)
         fbp_pkg::FBP_WAIT: begin
            if (any_flt) begin
               nxt.st = fbp_pkg::FBP_FAULT;
            end else if (on_rise) begin
               nxt.st = fbp_pkg::FBP_RUN;
            end
         end
         fbp_pkg::FBP_RUN: begin
            if (any_flt) begin
               nxt.st = fbp_pkg::FBP_FAULT;
            end
         end
         fbp_pkg::FBP_FAULT: begin
            if (!any_flt) begin
               nxt.st = fbp_pkg::FBP_WAIT;
            end
         end
         default: begin
            nxt.st = fbp_pkg::FBP_WAIT;
         end
      endcase

      // drive dies in the same cycle the fault is taken
      if (nxt.st != fbp_pkg::FBP_RUN) begin
         nxt.gate = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         st_ff <= fbp_pkg::STATE_RST;
      end else begin
         st_ff <= nxt;
      end
   end

   assign gate_drive_o     = st_ff.gate;
   assign hv_start_o       = st_ff.hv;
   assign soft_start_ref_o = st_ff.ss_ref;
   assign fault_o          = st_ff.flt;
   assign state_o          = st_ff.st;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_aoc_fourth;
      st_ff.st == fbp_pkg::FBP_RUN && st_ff.gate && in.aoc_cmp &&
      32'(st_ff.per) > BLANK && 32'(st_ff.aoc_cnt) == fbp_pkg::AOC_LIMIT - 1;
   endsequence

   sequence s_fault_off;
      st_ff.flt.aoc && !st_ff.gate;
   endsequence

   a_aoc_four_off: assert property (s_aoc_fourth |=> s_fault_off)
      else $error("fourth abnormal over-current did not stop drive");

   a_aoc_cnt_clear: assert property (
      st_ff.st == fbp_pkg::FBP_RUN && st_ff.gate && pulse_end && !aoc_trip
      |=> st_ff.aoc_cnt == '0)
      else $error("clean pulse did not clear abnormal counter");

   a_blank_ignore: assert property (
      st_ff.gate && 32'(st_ff.per) <= BLANK && !in.ilim_cmp && !in.ss_cmp && !any_flt
      |=> st_ff.gate)
      else $error("pulse ended inside short blanking");

   a_ovp_qualify: assert property (
      in.vcc_ov && 32'(st_ff.ov_tmr) == OV_CYC |=> st_ff.flt.supply_overvoltage_guard && !st_ff.gate)
      else $error("qualified over-voltage did not stop drive");

   a_ovp_latched: assert property (
      OVP_LATCH && st_ff.flt.supply_overvoltage_guard && !clr_all |=> st_ff.flt.supply_overvoltage_guard)
      else $error("latched over-voltage released without reset");

   a_cs_open_off: assert property (
      in.cs_open |=> !st_ff.gate && st_ff.st != fbp_pkg::FBP_RUN)
      else $error("open sense pin did not disable controller");

   a_duty_cap: assert property (
      st_ff.gate |-> 32'(st_ff.per) <= MAX_ON && st_ff.per != '0)
      else $error("pulse exceeded maximum duty");

   a_ovld_expire: assert property (
      st_ff.st == fbp_pkg::FBP_RUN && st_ff.ovld_on && 32'(st_ff.ovld_tmr) == OVLD_CYC - 1
      |=> st_ff.flt.ovld ##1 st_ff.st == fbp_pkg::FBP_FAULT)
      else $error("overload timer expiry did not fault");

   a_ss_from_zero: assert property (
      $rose(st_ff.st == fbp_pkg::FBP_RUN) |-> st_ff.ss_ref == '0 ##1 !$fell(st_ff.ss_ref[0]))
      else $error("soft-start ramp did not start from zero");

   a_therm_off: assert property (st_ff.flt.otp |-> !st_ff.gate)
      else $error("drive active during thermal fault");

   a_restart_edge: assert property (
      st_ff.st != fbp_pkg::FBP_RUN && !on_rise |=> st_ff.st != fbp_pkg::FBP_RUN)
      else $error("restart without start-level crossing");

endmodule : fbp_core

// ---- fbp_pkg.sv ----
// Purpose: shared constants and types of the flyback protection logic
// Assumes: one 250 MHz clock, synchronous active-high reset
// Notes:   long counts are copied into top-level parameters

package fbp_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ         = 250;
   localparam int CLK_PERIOD_NS   = 4;
   localparam int SHORT_BLANK_NS  = 120;
   localparam int SHORT_BLANK_CYC = (SHORT_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OV_QUAL_US      = 20;
   localparam int OV_QUAL_CYC     = OV_QUAL_US * CLK_MHZ;
   localparam int SS_DURATION_MS  = 8;
   localparam int SS_DURATION_CYC = SS_DURATION_MS * 1000 * CLK_MHZ;
   localparam int RECOVERY_S      = 1;
   localparam int RECOVERY_CYC    = RECOVERY_S * 1000000 * CLK_MHZ;
   localparam int OVLD_TIMER_CYC  = 1000000;
   localparam int PERIOD_CYC      = 4000;
   localparam int MAX_DUTY_PCT    = 80;
   localparam int AOC_LIMIT       = 4;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int PER_W = 16;
   localparam int TMR_W = 28;
   localparam int SS_W  = 8;
   localparam int AOC_W = 3;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FBP_WAIT  = 2'h0,
      FBP_RUN   = 2'h1,
      FBP_FAULT = 2'h2
   } fbp_st_e;

   typedef struct packed {
      logic aoc_cmp;
      logic ilim_cmp;
      logic ss_cmp;
      logic cs_open;
      logic vcc_ov;
      logic vcc_on;
      logic vcc_above_min;
      logic vcc_reset;
      logic bo_ok;
      logic therm_hot;
      logic therm_cool;
      logic fault_pin;
   } fbp_in_s;

   typedef struct packed {
      logic aoc;
      logic ovld;
      logic supply_overvoltage_guard;
      logic otp;
      logic pin;
   } fbp_flt_s;

   typedef struct packed {
      fbp_st_e          st;
      logic             gate;
      logic             hv;
      logic [PER_W-1:0] per;
      logic [AOC_W-1:0] aoc_cnt;
      logic             ovld_on;
      logic [TMR_W-1:0] ovld_tmr;
      logic [TMR_W-1:0] ov_tmr;
      logic             rec_run;
      logic [TMR_W-1:0] rec_tmr;
      logic [SS_W-1:0]  ss_ref;
      logic [TMR_W-1:0] ss_div;
      fbp_flt_s         flt;
      logic             vcc_on_prev;
      logic             bo_prev;
   } fbp_state_s;

   localparam fbp_state_s STATE_RST = '0;
   localparam logic [TMR_W-1:0] TMR_ONE = 28'h1;

endpackage : fbp_pkg

// ---- fbp_sync.sv ----
// Purpose: two-flop synchroniser for a vector of asynchronous levels
// Assumes: each bit is an independent level
// Notes:   bits are not coherent with each other

`timescale 1ns/100ps

module fbp_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         sys_clk_i,
   input  wire logic         sys_rst_i,
   // levels
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [1:0][W-1:0] sync_ff;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         sync_ff <= '0;
      end else begin
         sync_ff <= {sync_ff[0], d_i};
      end
   end

   assign q_o = sync_ff[1];

endmodule : fbp_sync

// ---- fbp_plant.sv ----
// Purpose: far-side model of the sense comparators around the power switch
// Assumes: sense ramps once per cycle of switch on-time, levels change at negedge
// Notes:   a zero trip point means that comparator never trips

`timescale 1ns/100ps

module fbp_plant (
   // clock
   input  wire logic       sys_clk_i,
   // switch and reference
   input  wire logic       gate_drive_i,
   input  wire logic [7:0] ss_ref_i,
   // trip points in on-time cycles
   input  wire logic [7:0] aoc_at_i,
   input  wire logic [7:0] ilim_at_i,
   // comparator levels
   output logic            aoc_cmp_o,
   output logic            ilim_cmp_o,
   output logic            ss_cmp_o
);
   // ----------------------------------------------------------------
   // sense ramp
   // ----------------------------------------------------------------
   logic [8:0] on_cnt;

   initial begin
      on_cnt     = 9'h0;
      aoc_cmp_o  = 1'b0;
      ilim_cmp_o = 1'b0;
      ss_cmp_o   = 1'b0;
   end

   // sense collapses when the switch opens, so all comparators fall
   always @(negedge sys_clk_i) begin
      on_cnt     <= gate_drive_i ? on_cnt + 9'h1 : 9'h0;
      // short spike only, so blanking alone decides if it is seen
      aoc_cmp_o  <= gate_drive_i && (aoc_at_i != 8'h0) && (on_cnt >= {1'b0, aoc_at_i})
                    && (on_cnt < {1'b0, aoc_at_i} + 9'h4);
      ilim_cmp_o <= gate_drive_i && (ilim_at_i != 8'h0) && (on_cnt >= {1'b0, ilim_at_i});
      ss_cmp_o   <= gate_drive_i && (on_cnt > {1'b0, ss_ref_i});
   end
endmodule : fbp_plant

// ---- test_fbp_core.sv ----
// Purpose: self-checking bench of the flyback protection core
// Assumes: shortened counts, abnormal over-current, over-voltage and fault pin built as latched
// Notes:   every restart replays and times the soft-start ramp

`timescale 1ns/100ps

`define CHK(nm, exp, got) begin \
   check_count++; \
   if ((got) !== (exp)) begin \
      mismatches++; \
      $display("wrong value %s expected %0h seen %0h", nm, exp, got); \
   end \
end

module test_fbp_core;
   // ----------------------------------------------------------------
   // set-up
   // ----------------------------------------------------------------
   localparam int PER = 100;
   localparam int SSC = 2560;
   logic               sys_clk_i;
   logic               sys_rst_i;
   fbp_pkg::fbp_in_s   drv;
   fbp_pkg::fbp_in_s   pins;
   logic               gate;
   logic               hv;
   logic [7:0]         ss_ref;
   fbp_pkg::fbp_flt_s  flt;
   fbp_pkg::fbp_st_e   st;
   logic [7:0]         aoc_at;
   logic [7:0]         ilim_at;
   logic               p_aoc;
   logic               p_ilim;
   logic               p_ss;
   int                 mismatches;
   int                 check_count;
   int                 cyc;
   int                 len;
   integer             seed;

   fbp_core #(.PERIOD_CYC(PER), .OV_CYC(10), .SS_CYC(SSC), .REC_CYC(50), .OVLD_CYC(20))
   u_fbp_core (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .pins_i(pins),
      .gate_drive_o(gate), .hv_start_o(hv), .soft_start_ref_o(ss_ref), .fault_o(flt),
      .state_o(st));

   fbp_plant u_fbp_plant (.sys_clk_i(sys_clk_i), .gate_drive_i(gate), .ss_ref_i(ss_ref),
      .aoc_at_i(aoc_at), .ilim_at_i(ilim_at), .aoc_cmp_o(p_aoc), .ilim_cmp_o(p_ilim),
      .ss_cmp_o(p_ss));

   always_comb begin
      pins          = drv;
      pins.aoc_cmp  = p_aoc;
      pins.ilim_cmp = p_ilim;
      pins.ss_cmp   = p_ss;
   end

   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end

   // ----------------------------------------------------------------
   // expectations and helpers
   // ----------------------------------------------------------------
   function automatic int max_on(input int period);
      return period * fbp_pkg::MAX_DUTY_PCT / 100;
   endfunction : max_on

   function automatic int ramp_cyc(input int ss_cyc);
      return (ss_cyc / 256) * 255;
   endfunction : ramp_cyc

   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask : idle

   task automatic wait_st(input fbp_pkg::fbp_st_e s, input int lim);
      int n;
      n = 0;
      while (st !== s && n < lim) begin
         @(negedge sys_clk_i);
         n++;
      end
   endtask : wait_st

   // restart at a fresh start crossing and time the reference ramp
   task automatic start_up();
      int n;
      n = 0;
      drv.vcc_on = 1'b0;
      idle(4);
      drv.vcc_on = 1'b1;
      wait_st(fbp_pkg::FBP_RUN, 10);
      `CHK("state after start", fbp_pkg::FBP_RUN, st)
      `CHK("ramp at start", 8'h00, ss_ref)
      while (ss_ref !== 8'hFF && n < 4000) begin
         @(negedge sys_clk_i);
         n++;
      end
      `CHK("ramp length", 1'b1, (n - ramp_cyc(SSC)) inside {[-15:15]})
   endtask : start_up

   // plant changes only while the switch is open
   task automatic pulse_with(input logic [7:0] a, input logic [7:0] l, output int n);
      int k;
      k = 0;
      while (gate !== 1'b0 && k < 200) begin
         @(negedge sys_clk_i);
         k++;
      end
      aoc_at  = a;
      ilim_at = l;
      while (gate !== 1'b1 && k < 400) begin
         @(negedge sys_clk_i);
         k++;
      end
      n = 0;
      while (gate === 1'b1 && n < 200) begin
         @(negedge sys_clk_i);
         n++;
      end
   endtask : pulse_with

   task automatic clear_by(input bit bo);
      if (bo) drv.bo_ok = 1'b0;
      else drv.vcc_reset = 1'b1;
      idle(4);
      drv.bo_ok     = 1'b1;
      drv.vcc_reset = 1'b0;
      idle(20);
      `CHK("faults cleared", 5'h00, flt)
      `CHK("wait for crossing", fbp_pkg::FBP_WAIT, st)
      aoc_at  = 8'h0;
      ilim_at = 8'd50;
   endtask : clear_by

   task automatic end_test(input string nm);
      $display("test %s done", nm);
      idle($unsigned($random(seed)) % 16);
   endtask : end_test

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop

   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 40000) begin
         mismatches++;
         report_and_stop();
      end
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      seed = 32'hc7063857;
      mismatches = 0;
      check_count = 0;
      drv = '0;
      drv.bo_ok = 1'b1;
      drv.vcc_above_min = 1'b1;
      aoc_at = 8'h0;
      ilim_at = 8'd50;
      sys_rst_i = 1'b1;
      idle(6);
      sys_rst_i = 1'b0;
      `CHK("reset state", fbp_pkg::FBP_WAIT, st)
      `CHK("reset drive", 1'b0, gate)
      drv.cs_open = 1'b1;
      drv.vcc_on = 1'b1;
      idle(12);
      `CHK("open sense drive", 1'b0, gate)
      drv.cs_open = 1'b0;
      end_test("open sense");
      start_up();
      for (int i = 0; i < 4; i++) begin
         pulse_with(8'd8, 8'd50, len);
         `CHK("blanked spike", 1'b1, len > 45)
      end
      // three trips, one current-limit-ended pulse, three trips: the clean one resets the count
      for (int i = 0; i < 7; i++) begin
         pulse_with((i == 3) ? 8'h0 : 8'd35 + 8'($unsigned($random(seed)) % 25),
                    (i == 3) ? 8'd50 : 8'h0, len);
         `CHK("trip ends pulse", 1'b1, len < max_on(PER))
      end
      idle(2);
      `CHK("four in a row", 1'b0, flt.aoc)
      pulse_with(8'd40, 8'h0, len);
      idle(2);
      `CHK("abnormal fault", 1'b1, flt.aoc)
      `CHK("fault state", fbp_pkg::FBP_FAULT, st)
      drv.vcc_on = 1'b0;
      drv.vcc_above_min = 1'b0;
      idle(120);
      `CHK("latched stays off", 1'b0, gate)
      `CHK("supply recharges", 1'b1, hv)
      drv.vcc_on = 1'b1;
      drv.vcc_above_min = 1'b1;
      idle(6);
      `CHK("recharge stops", 1'b0, hv)
      `CHK("latched fault held", fbp_pkg::FBP_FAULT, st)
      clear_by(1'b0);
      end_test("abnormal over-current");
      start_up();
      pulse_with(8'h0, 8'h0, len);
      `CHK("duty cap", max_on(PER), len)
      idle(60);
      `CHK("overload fault", 1'b1, flt.ovld)
      `CHK("overload drive", 1'b0, gate)
      clear_by(1'b1);
      end_test("overload");
      start_up();
      drv.vcc_ov = 1'b1;
      idle(6);
      drv.vcc_ov = 1'b0;
      idle(20);
      `CHK("short surge", 1'b0, flt.supply_overvoltage_guard)
      drv.vcc_ov = 1'b1;
      idle(18);
      `CHK("surge fault", 1'b1, flt.supply_overvoltage_guard)
      `CHK("surge drive", 1'b0, gate)
      drv.vcc_ov = 1'b0;
      idle(20);
      `CHK("surge latched", 1'b1, flt.supply_overvoltage_guard)
      clear_by(1'b1);
      end_test("supply over-voltage");
      start_up();
      drv.therm_hot = 1'b1;
      idle(6);
      `CHK("hot fault", 1'b1, flt.otp)
      `CHK("hot drive", 1'b0, gate)
      drv.therm_hot = 1'b0;
      idle(10);
      `CHK("hot held", 1'b1, flt.otp)
      drv.therm_cool = 1'b1;
      idle(4);
      drv.therm_cool = 1'b0;
      idle(6);
      `CHK("cooled", 1'b0, flt.otp)
      start_up();
      drv.therm_hot = 1'b1;
      idle(6);
      drv.therm_hot = 1'b0;
      `CHK("hot before line drop", 1'b1, flt.otp)
      clear_by(1'b1);
      start_up();
      drv.therm_hot = 1'b1;
      idle(6);
      drv.therm_hot = 1'b0;
      `CHK("hot before supply reset", 1'b1, flt.otp)
      clear_by(1'b0);
      end_test("thermal");
      start_up();
      drv.fault_pin = 1'b1;
      idle(6);
      drv.fault_pin = 1'b0;
      idle(10);
      `CHK("fault pin latched", 1'b1, flt.pin)
      `CHK("fault pin drive", 1'b0, gate)
      clear_by(1'b0);
      end_test("fault pin");
      report_and_stop();
   end
endmodule : test_fbp_core
